// >>> inc/plcs_defs.svh
`ifndef PLCS_DEFS_SVH
`define PLCS_DEFS_SVH

// register indices; byte address is four times the index
`define PLCS_IDX_LINK_CTL 12'h050
`define PLCS_IDX_LINK_STS 12'h052
`define PLCS_IDX_SW_CTL 12'h060

// link control word bits
`define PLCS_CTL_RCB 3
`define PLCS_CTL_DIS 4
`define PLCS_CTL_RETRAIN 5
`define PLCS_CTL_COMMON_CLOCK_CONFIG 6
`define PLCS_CTL_EXTENDED_SYNC 7
`define PLCS_CTL_CPM 8

// link status word fields
`define PLCS_STS_SPEED_LSB 0
`define PLCS_STS_SPEED_MSB 3
`define PLCS_STS_WIDTH_LSB 4
`define PLCS_STS_WIDTH_MSB 9
`define PLCS_STS_TRAINING_ERROR 10
`define PLCS_STS_TRAIN 11
`define PLCS_STS_SCLK 12
`define PLCS_STS_DLLA 13

// switch control word bits
`define PLCS_SW_UNLOCK 0

// field codes and reset values
`define PLCS_SPEED_RST 4'h1
`define PLCS_SPEED_GEN1 4'h1
`define PLCS_SPEED_GEN2 4'h2
`define PLCS_WIDTH_X1 6'h01
`define PLCS_WIDTH_X2 6'h02
`define PLCS_WIDTH_X4 6'h04
`define PLCS_HTRANS_NONSEQ 2'h2
`define PLCS_HSIZE_WORD 3'h2

`endif

// >>> inc/plcs_pkg.sv
package plcs_pkg;

    // status coming from the training and data link state machines
    typedef struct packed {
        logic [3:0] link_speed;
        logic [5:0] link_width;
        logic training_in_progress;
        logic training_error;
        logic dl_link_active_status;
    } plcs_ltssm_stat_t;

    // controls presented to the training state machine
    typedef struct packed {
        logic link_disable;
        logic link_retrain;
        logic common_clock_config;
        logic extended_sync;
        logic slot_clock_config;
    } plcs_ltssm_ctl_t;

    // ahb data phase tracking
    typedef enum logic [1:0] {
        PLCS_IDLE,
        PLCS_WR,
        PLCS_RD_WAIT,
        PLCS_RD_DONE
    } plcs_phase_t;

endpackage : plcs_pkg

// >>> hw/plcs_link_regs.sv
// The AHB-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "plcs_defs.svh"

module plcs_link_regs #(
    parameter bit UPSTREAM_PORT = 1'b0,
    parameter bit REV_1_0A = 1'b1,
    parameter logic [5:0] INIT_WIDTH = 6'h04
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic upstream_common_clock_strap_i,
    input wire logic downstream_common_clock_strap_i,
    input wire logic cfg_load_i,
    input wire logic cfg_slot_clock_i,
    input wire plcs_pkg::plcs_ltssm_stat_t ltssm_stat_i,
    output plcs_pkg::plcs_ltssm_ctl_t ltssm_ctl_o
);

    plcs_pkg::plcs_phase_t phase;
    logic [11:0] addr_idx;
    logic addr_hit;
    logic accept;
    logic wr_ctl;
    logic wr_sw;
    logic [31:0] rd_word;

    logic link_disable;
    logic link_retrain;
    logic common_clock_config;
    logic extended_sync;
    logic register_write_unlock;
    logic slot_clock_config;
    logic strap_taken;
    logic [3:0] link_speed;
    logic [5:0] link_width;
    logic training_in_progress;
    logic training_error;
    logic dl_link_active_status;
    plcs_pkg::plcs_phase_t next_phase;
    logic next_link_disable;
    logic next_common_clock_config;
    logic next_extended_sync;
    logic next_register_write_unlock;
    logic retrain_allowed;
    logic next_link_retrain;
    logic next_slot_clock_config;
    logic speed_legal;
    logic width_legal;
    logic [3:0] next_link_speed;
    logic [5:0] next_link_width;
    logic training_start;
    logic next_training_error;
    logic [15:0] ctl_view;
    logic [15:0] sts_view;
    logic [15:0] sw_view;

    // upper address bits must be zero for a hit
    assign addr_hit = (haddr_i[31:14] == 18'h00000) && (haddr_i[1:0] == 2'h0);
    assign accept = hsel_i && hready_i && (htrans_i == `PLCS_HTRANS_NONSEQ)
        && (hsize_i == `PLCS_HSIZE_WORD);

    // address phase capture; unmapped addresses get a harmless index
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            addr_idx <= 12'h000;
        end
        else if (accept)
        begin
            addr_idx <= addr_hit ? haddr_i[13:2] : 12'hFFF;
        end
    end

    // next bus phase; reads take one wait state so a write just before is seen
    always_comb
    begin
        next_phase = plcs_pkg::PLCS_IDLE;
        if (accept)
        begin
            next_phase = hwrite_i ? plcs_pkg::PLCS_WR : plcs_pkg::PLCS_RD_WAIT;
        end
        else if (phase == plcs_pkg::PLCS_RD_WAIT)
        begin
            next_phase = plcs_pkg::PLCS_RD_DONE;
        end
    end

    // bus phase register
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            phase <= plcs_pkg::PLCS_IDLE;
        end
        else
        begin
            phase <= next_phase;
        end
    end

    assign hreadyout_o = (phase != plcs_pkg::PLCS_RD_WAIT);
    assign hresp_o = 1'b0;
    assign wr_ctl = (phase == plcs_pkg::PLCS_WR) && (addr_idx == `PLCS_IDX_LINK_CTL);
    assign wr_sw = (phase == plcs_pkg::PLCS_WR) && (addr_idx == `PLCS_IDX_SW_CTL);

    // link control as software sees it; hardwired bits kept explicit
    always_comb
    begin
        ctl_view = 16'h0000;
        ctl_view[`PLCS_CTL_RCB] = 1'b0;
        ctl_view[`PLCS_CTL_DIS] = link_disable;
        ctl_view[`PLCS_CTL_RETRAIN] = 1'b0;
        ctl_view[`PLCS_CTL_COMMON_CLOCK_CONFIG] = common_clock_config;
        ctl_view[`PLCS_CTL_EXTENDED_SYNC] = extended_sync;
        ctl_view[`PLCS_CTL_CPM] = 1'b0;
    end

    // link status as software sees it
    always_comb
    begin
        sts_view = 16'h0000;
        sts_view[`PLCS_STS_SPEED_MSB:`PLCS_STS_SPEED_LSB] = link_speed;
        sts_view[`PLCS_STS_WIDTH_MSB:`PLCS_STS_WIDTH_LSB] = link_width;
        sts_view[`PLCS_STS_TRAINING_ERROR] = training_error;
        sts_view[`PLCS_STS_TRAIN] = training_in_progress;
        sts_view[`PLCS_STS_SCLK] = slot_clock_config;
        sts_view[`PLCS_STS_DLLA] = dl_link_active_status;
    end

    // switch control holds only the unlock bit
    always_comb
    begin
        sw_view = 16'h0000;
        sw_view[`PLCS_SW_UNLOCK] = register_write_unlock;
    end

    // read mux; upper half of every word reads zero
    always_comb
    begin
        rd_word = 32'h00000000;
        case (addr_idx)
            `PLCS_IDX_LINK_CTL:
            begin
                rd_word = {16'h0000, ctl_view};
            end
            `PLCS_IDX_LINK_STS:
            begin
                rd_word = {16'h0000, sts_view};
            end
            `PLCS_IDX_SW_CTL:
            begin
                rd_word = {16'h0000, sw_view};
            end
            default:
            begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    // read data registered at the end of the wait state
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            hrdata_o <= 32'h00000000;
        end
        else if (phase == plcs_pkg::PLCS_RD_WAIT)
        begin
            hrdata_o <= rd_word;
        end
    end

    // control fields take write data only on a link control write
    always_comb
    begin
        next_link_disable = link_disable;
        next_common_clock_config = common_clock_config;
        next_extended_sync = extended_sync;
        if (wr_ctl)
        begin
            next_link_disable = hwdata_i[`PLCS_CTL_DIS];
            next_common_clock_config = hwdata_i[`PLCS_CTL_COMMON_CLOCK_CONFIG];
            next_extended_sync = hwdata_i[`PLCS_CTL_EXTENDED_SYNC];
        end
    end

    // writable link control fields; retrain-related fields land with the pulse
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            link_disable <= 1'b0;
            common_clock_config <= 1'b0;
            extended_sync <= 1'b0;
        end
        else
        begin
            link_disable <= next_link_disable;
            common_clock_config <= next_common_clock_config;
            extended_sync <= next_extended_sync;
        end
    end

    // upstream retrain is locked out until software unlocks the switch registers
    assign retrain_allowed = !UPSTREAM_PORT || register_write_unlock;
    assign next_link_retrain = wr_ctl && hwdata_i[`PLCS_CTL_RETRAIN] && retrain_allowed;

    // one-cycle retrain request, same edge as the other fields update
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            link_retrain <= 1'b0;
        end
        else
        begin
            link_retrain <= next_link_retrain;
        end
    end

    // unlock bit follows a switch control write, else holds
    assign next_register_write_unlock = wr_sw ? hwdata_i[`PLCS_SW_UNLOCK] : register_write_unlock;

    // switch control unlock bit
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            register_write_unlock <= 1'b0;
        end
        else
        begin
            register_write_unlock <= next_register_write_unlock;
        end
    end

    // serial configuration load beats the strap, even on the first edge
    always_comb
    begin
        next_slot_clock_config = slot_clock_config;
        if (cfg_load_i)
        begin
            next_slot_clock_config = cfg_slot_clock_i;
        end
        else if (!strap_taken)
        begin
            next_slot_clock_config = UPSTREAM_PORT ? upstream_common_clock_strap_i
                : downstream_common_clock_strap_i;
        end
    end

    // strap caught on first edge after reset release, not in the reset branch
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            strap_taken <= 1'b0;
            slot_clock_config <= 1'b0;
        end
        else
        begin
            strap_taken <= 1'b1;
            slot_clock_config <= next_slot_clock_config;
        end
    end

    // only documented codes are taken; a reserved code leaves the field alone
    assign speed_legal = (ltssm_stat_i.link_speed == `PLCS_SPEED_GEN1)
        || (ltssm_stat_i.link_speed == `PLCS_SPEED_GEN2);
    assign width_legal = (ltssm_stat_i.link_width == `PLCS_WIDTH_X1)
        || (ltssm_stat_i.link_width == `PLCS_WIDTH_X2)
        || (ltssm_stat_i.link_width == `PLCS_WIDTH_X4);
    assign next_link_speed = speed_legal ? ltssm_stat_i.link_speed : link_speed;
    assign next_link_width = width_legal ? ltssm_stat_i.link_width : link_width;

    // negotiated speed and width registers
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            link_speed <= `PLCS_SPEED_RST;
            link_width <= INIT_WIDTH;
        end
        else
        begin
            link_speed <= next_link_speed;
            link_width <= next_link_width;
        end
    end

    // live state bits sampled once
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            training_in_progress <= 1'b0;
            dl_link_active_status <= 1'b0;
        end
        else
        begin
            training_in_progress <= ltssm_stat_i.training_in_progress;
            dl_link_active_status <= ltssm_stat_i.dl_link_active_status;
        end
    end

    // a fresh training clears the flag, but an error in the same cycle wins
    assign training_start = ltssm_stat_i.training_in_progress && !training_in_progress;
    always_comb
    begin
        next_training_error = training_error;
        if (REV_1_0A && ltssm_stat_i.training_error)
        begin
            next_training_error = 1'b1;
        end
        else if (training_start)
        begin
            next_training_error = 1'b0;
        end
    end

    // sticky error register
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            training_error <= 1'b0;
        end
        else
        begin
            training_error <= next_training_error;
        end
    end

    // link disable has no function on the upstream port
    assign ltssm_ctl_o.link_disable = link_disable && !UPSTREAM_PORT;
    assign ltssm_ctl_o.link_retrain = link_retrain;
    assign ltssm_ctl_o.common_clock_config = common_clock_config;
    assign ltssm_ctl_o.extended_sync = extended_sync;
    assign ltssm_ctl_o.slot_clock_config = slot_clock_config;

endmodule : plcs_link_regs

`default_nettype wire

// >>> verif/plcs_link_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none

module plcs_link_regs_checker #(
    parameter bit UPSTREAM_PORT = 1'b0
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic [31:0] hrdata_o,
    input wire logic cfg_load_i,
    input wire logic cfg_slot_clock_i,
    input wire plcs_pkg::plcs_ltssm_ctl_t ltssm_ctl_o
);
    logic taken;
    logic wr_ctl_q;
    logic rd_q;
    logic rd_ctl_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    // accepted address phase; link control sits at byte 0x140
    assign taken = hsel_i && hready_i && (htrans_i == 2'h2) && (hsize_i == 3'h2);

    // data phase markers, since the address is gone by then
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wr_ctl_q <= 1'h0;
            rd_q <= 1'h0;
            rd_ctl_q <= 1'h0;
        end
        else
        begin
            wr_ctl_q <= taken && hwrite_i && (haddr_i == 32'h0000_0140);
            rd_q <= taken && !hwrite_i;
            rd_ctl_q <= taken && !hwrite_i && (haddr_i == 32'h0000_0140);
        end
    end

    property p_rd_wait;
        rd_q |-> !hreadyout_o ##1 hreadyout_o;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_nowait;
        taken && hwrite_i |=> hreadyout_o;
    endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_rd_pad;
        rd_q |=> hrdata_o[31:16] == 16'h0000;
    endproperty
    a_rd_pad: assert property (p_rd_pad) else $error("upper read bits set");
    property p_rd_ctl_zero;
        rd_ctl_q |=> hrdata_o[15:8] == 8'h00 && !hrdata_o[5] && hrdata_o[3:2] == 2'h0;
    endproperty
    a_rd_ctl_zero: assert property (p_rd_ctl_zero) else $error("fixed control bit set");
    property p_retrain_pulse;
        ltssm_ctl_o.link_retrain |=> !ltssm_ctl_o.link_retrain;
    endproperty
    a_retrain_pulse: assert property (p_retrain_pulse) else $error("retrain longer than one cycle");
    property p_retrain_cause;
        ltssm_ctl_o.link_retrain |-> $past(wr_ctl_q) && $past(hwdata_i[5]);
    endproperty
    a_retrain_cause: assert property (p_retrain_cause) else $error("retrain without write");
    property p_retrain_fire;
        !UPSTREAM_PORT && wr_ctl_q && hwdata_i[5] |=> ltssm_ctl_o.link_retrain;
    endproperty
    a_retrain_fire: assert property (p_retrain_fire) else $error("retrain missing");
    property p_ctl_update;
        wr_ctl_q |=> ltssm_ctl_o.common_clock_config == $past(hwdata_i[6])
            && ltssm_ctl_o.extended_sync == $past(hwdata_i[7])
            && ltssm_ctl_o.link_disable == ($past(hwdata_i[4]) && !UPSTREAM_PORT);
    endproperty
    a_ctl_update: assert property (p_ctl_update) else $error("control fields not applied");
    property p_ctl_hold;
        !wr_ctl_q |=> $stable({ltssm_ctl_o.link_disable, ltssm_ctl_o.common_clock_config, ltssm_ctl_o.extended_sync});
    endproperty
    a_ctl_hold: assert property (p_ctl_hold) else $error("control changed without write");
    property p_slot_load;
        cfg_load_i |=> ltssm_ctl_o.slot_clock_config == $past(cfg_slot_clock_i);
    endproperty
    a_slot_load: assert property (p_slot_load) else $error("slot clock load lost");
endmodule : plcs_link_regs_checker

bind plcs_link_regs plcs_link_regs_checker #(.UPSTREAM_PORT(UPSTREAM_PORT)) u_plcs_link_regs_checker (
    .clock_i(clock_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o), .cfg_load_i(cfg_load_i),
    .cfg_slot_clock_i(cfg_slot_clock_i), .ltssm_ctl_o(ltssm_ctl_o)
);

`default_nettype wire

// >>> verif/test_pcie_port_link_control_status.sv
`timescale 1ns/100ps
`default_nettype none
`include "plcs_defs.svh"

module test_pcie_port_link_control_status;
    localparam logic [31:0] CTL = {18'h0, `PLCS_IDX_LINK_CTL, 2'h0};
    localparam logic [31:0] STS = {18'h0, `PLCS_IDX_LINK_STS, 2'h0};
    localparam logic [31:0] SWC = {18'h0, `PLCS_IDX_SW_CTL, 2'h0};
    logic clock_i, nrst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, cfg_load_i, cfg_slot_clock_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, seed, w, r;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    plcs_pkg::plcs_ltssm_stat_t stat;
    plcs_pkg::plcs_ltssm_ctl_t ctl;
    logic [3:0] sp_m;
    logic [5:0] wd_m;
    logic training_error_m, sclk_m;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;

    plcs_link_regs u_plcs_link_regs (
        .clock_i(clock_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
        .upstream_common_clock_strap_i(1'h0), .downstream_common_clock_strap_i(1'h1),
        .cfg_load_i(cfg_load_i), .cfg_slot_clock_i(cfg_slot_clock_i), .ltssm_stat_i(stat), .ltssm_ctl_o(ctl)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // expected status word from the model and the driven levels
    function automatic logic [31:0] sts_word();
        return {18'h0, stat.dl_link_active_status, sclk_m, stat.training_in_progress, training_error_m, wd_m, sp_m};
    endfunction : sts_word

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one single transfer; hready sampled at the rising edge, data taken there
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel_i <= 1'h1;
        haddr_i <= a;
        hwrite_i <= wr;
        htrans_i <= `PLCS_HTRANS_NONSEQ;
        hsize_i <= `PLCS_HSIZE_WORD;
        do @(posedge clock_i); while (hreadyout_o !== 1'h1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clock_i); while (hreadyout_o !== 1'h1);
        q = hrdata_o;
        check({31'h0, hresp_o}, 32'h0);
    endtask : xfer

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        clock_i = 1'h0;
        forever #20 clock_i = ~clock_i;
    end

    // hang guard, far above the hundred or so cycles needed
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        nrst_i = 1'h0;
        hsel_i = 1'h0;
        haddr_i = 32'h0;
        htrans_i = 2'h0;
        hwrite_i = 1'h0;
        hsize_i = 3'h2;
        hwdata_i = 32'h0;
        cfg_load_i = 1'h0;
        cfg_slot_clock_i = 1'h0;
        stat = '{4'h1, 6'h04, 1'h0, 1'h0, 1'h0};
        sp_m = 4'h1;
        wd_m = 6'h04;
        training_error_m = 1'h0;
        sclk_m = 1'h1;
        seed = 32'h3E986689;
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'h1;
        @(posedge clock_i);
        xfer(1'h0, CTL, 32'h0, r);
        check(r, 32'h0);
        xfer(1'h0, STS, 32'h0, r);
        check(r, sts_word());
        $display("reset values done");
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            w = (seed & 32'hFFFF_FFFC) | (i[0] ? 32'h0000_0020 : 32'h0);
            xfer(1'h1, CTL, w, r);
            @(negedge clock_i);
            check({27'h0, ctl}, {27'h0, w[4], w[5], w[6], w[7], sclk_m});
            @(posedge clock_i);
            xfer(1'h0, CTL, 32'h0, r);
            check(r, w & 32'h0000_00D0);
        end
        $display("control writes done");
        // reserved speed and width codes must leave the last legal value
        for (int i = 0; i < 6; i++)
        begin
            stat <= '{i[3:0] & 4'h3, 6'h01 << i, i[0], 1'h0, i[1]};
            if (i % 4 == 1 || i % 4 == 2)
                sp_m = i[3:0] & 4'h3;
            if (i < 3)
                wd_m = 6'h01 << i;
            xfer(1'h0, STS, 32'h0, r);
            check(r, sts_word());
        end
        stat.training_error <= 1'h1;
        @(posedge clock_i);
        stat.training_error <= 1'h0;
        training_error_m = 1'h1;
        xfer(1'h0, STS, 32'h0, r);
        check(r, sts_word());
        $display("status tracking done");
        cfg_load_i <= 1'h1;
        @(posedge clock_i);
        cfg_load_i <= 1'h0;
        sclk_m = 1'h0;
        xfer(1'h0, STS, 32'h0, r);
        check(r, sts_word());
        xfer(1'h1, STS, 32'hFFFF_FFFF, r);
        xfer(1'h1, CTL + 32'h4, 32'hFFFF_FFFF, r);
        xfer(1'h0, CTL + 32'h4, 32'h0, r);
        check(r, 32'h0);
        xfer(1'h0, STS, 32'h0, r);
        check(r, sts_word());
        xfer(1'h1, SWC, 32'h1, r);
        xfer(1'h0, SWC, 32'h0, r);
        check(r, 32'h1);
        $display("load and map done");
        tally_and_finish();
    end
endmodule : test_pcie_port_link_control_status

`default_nettype wire
